// ==== core/hwm_monitor_regs.sv ====
// Purpose: Monitor register bank with its two-wire serial slave port
// Assumes: Serial clock far slower than core_clk; results arrive from the measuring engine
// Notes: Open-drain data pin split into input, output and enable
`timescale 1ns/100ps

// Summary of operation
// - Low byte of each 10-bit result carries result bits 1:0 in bits 7:6.
// - High byte of each 10-bit result carries bits 9:2; read-only, resets zero.
// - Fan counts are 16 bits, low byte then high byte; read-only, reset zero.
// - Each tach setup holds three-wire, blanking, dwell and window fields, two bits.
// - Control register is read/write; bit 6 runs or halts measurement; resets zero.
// - Single-pass trigger register is read/write, all bits reserved, resets zero.
// - First byte after a write address loads the pointer, which persists.
module hwm_monitor_regs #(
  parameter logic [6:0] DEV_ADDR = hwm_pkg::DEFAULT_DEV_ADDR
) (
  input wire logic core_clk, // Core clock, 125 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic sclIn, // Serial clock pin
  input wire logic sdaIn, // Serial data pin level
  output logic sdaOut, // Serial data drive value, always low
  output logic sdaOe, // Serial data drive enable
  input wire logic resultValid, // Result word strobe from engine
  input wire hwm_pkg::hwm_result_t resultWord, // Result channel and value
  input wire logic passDone, // Engine finished a single pass
  output logic runEnable, // Continuous measurement enabled
  output logic passStart, // One-cycle request for a single pass
  output hwm_pkg::hwm_tach_cfg_t [3:0] tachCfg // Tach setup per fan
);

  typedef enum logic [9:0] {
    ST_IDLE = 10'b0000000001,
    ST_ADDR = 10'b0000000010,
    ST_ADDR_ACK = 10'b0000000100,
    ST_PTR = 10'b0000001000,
    ST_PTR_ACK = 10'b0000010000,
    ST_WDATA = 10'b0000100000,
    ST_WDATA_ACK = 10'b0001000000,
    ST_RDATA = 10'b0010000000,
    ST_RACK = 10'b0100000000,
    ST_RLOAD = 10'b1000000000
  } hwm_state_t;

  // ==========================================================
  // Pointer decode
  function automatic hwm_pkg::hwm_decode_t hwm_decode(input logic [7:0] ptr);
    hwm_pkg::hwm_decode_t d;
    d = '{valid: 1'b1, isResult: 1'b1, chan: 4'h0, high: 1'b0};
    case (ptr)
      hwm_pkg::OFF_CORE_SUPPLY_LOW_BITS: d.chan = hwm_pkg::CH_CORE;
      hwm_pkg::OFF_ZONE3_TEMP_LOW_BITS: d.chan = hwm_pkg::CH_ZONE3;
      hwm_pkg::OFF_ZONE1_TEMP_LOW_BITS: d.chan = hwm_pkg::CH_ZONE1;
      hwm_pkg::OFF_RAIL_3V3_LOW_BITS: d.chan = hwm_pkg::CH_3V3;
      hwm_pkg::OFF_RAIL_5V_LOW_BITS: d.chan = hwm_pkg::CH_5V;
      hwm_pkg::OFF_RAIL_2V5_LOW_BITS: d.chan = hwm_pkg::CH_2V5;
      hwm_pkg::OFF_RAIL_12V_LOW_BITS: d.chan = hwm_pkg::CH_12V;
      hwm_pkg::OFF_ZONE2_TEMP_LOW_BITS: d.chan = hwm_pkg::CH_ZONE2;
      hwm_pkg::OFF_RAIL_2V5_HIGH_BITS: d = '{1'b1, 1'b1, hwm_pkg::CH_2V5, 1'b1};
      hwm_pkg::OFF_CORE_SUPPLY_HIGH_BITS: d = '{1'b1, 1'b1, hwm_pkg::CH_CORE, 1'b1};
      hwm_pkg::OFF_RAIL_3V3_HIGH_BITS: d = '{1'b1, 1'b1, hwm_pkg::CH_3V3, 1'b1};
      hwm_pkg::OFF_RAIL_5V_HIGH_BITS: d = '{1'b1, 1'b1, hwm_pkg::CH_5V, 1'b1};
      hwm_pkg::OFF_RAIL_12V_HIGH_BITS: d = '{1'b1, 1'b1, hwm_pkg::CH_12V, 1'b1};
      hwm_pkg::OFF_ZONE1_TEMP_HIGH_BITS: d = '{1'b1, 1'b1, hwm_pkg::CH_ZONE1, 1'b1};
      hwm_pkg::OFF_ZONE2_TEMP_HIGH_BITS: d = '{1'b1, 1'b1, hwm_pkg::CH_ZONE2, 1'b1};
      hwm_pkg::OFF_ZONE3_TEMP_HIGH_BITS: d = '{1'b1, 1'b1, hwm_pkg::CH_ZONE3, 1'b1};
      hwm_pkg::OFF_FAN1_COUNT_LOW: d.chan = hwm_pkg::CH_FAN1;
      hwm_pkg::OFF_FAN1_COUNT_HIGH: d = '{1'b1, 1'b1, hwm_pkg::CH_FAN1, 1'b1};
      hwm_pkg::OFF_FAN2_COUNT_LOW: d.chan = hwm_pkg::CH_FAN2;
      hwm_pkg::OFF_FAN2_COUNT_HIGH: d = '{1'b1, 1'b1, hwm_pkg::CH_FAN2, 1'b1};
      hwm_pkg::OFF_FAN1_TACH_SETUP, hwm_pkg::OFF_FAN2_TACH_SETUP,
      hwm_pkg::OFF_FAN3_TACH_SETUP, hwm_pkg::OFF_FAN4_TACH_SETUP,
      hwm_pkg::OFF_MONITOR_CONTROL, hwm_pkg::OFF_SINGLE_PASS_TRIGGER: d.isResult = 1'b0;
      default: d = '{1'b0, 1'b0, 4'h0, 1'b0};
    endcase
    return d;
  endfunction : hwm_decode

  hwm_state_t state_reg;
  logic sclMeta_reg, sclSync_reg, sclLast_reg;
  logic sdaMeta_reg, sdaSync_reg, sdaLast_reg;
  logic [7:0] shift_reg;
  logic [7:0] txShift_reg;
  logic [3:0] bitCnt_reg;
  logic isRead_reg;
  logic [7:0] ptr_reg;
  logic [7:0] readByte_reg;
  logic [7:0] control_reg;
  logic [7:0] trigger_reg;
  logic oneShotActive_reg;
  logic [15:0] memData;
  logic sclRise, sclFall, startSeen, stopSeen, byteDone, wrEn, storeEn;
  hwm_pkg::hwm_decode_t ptrDec;
  hwm_pkg::hwm_result_t storeWord;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sclLast_reg <= 1'b1;
      sdaMeta_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      sdaLast_reg <= 1'b1;
    end else begin
      sclMeta_reg <= sclIn;
      sclSync_reg <= sclMeta_reg;
      sclLast_reg <= sclSync_reg;
      sdaMeta_reg <= sdaIn;
      sdaSync_reg <= sdaMeta_reg;
      sdaLast_reg <= sdaSync_reg;
    end
  end

  assign sclRise = sclSync_reg && !sclLast_reg;
  assign sclFall = !sclSync_reg && sclLast_reg;
  assign startSeen = sclSync_reg && sclLast_reg && sdaLast_reg && !sdaSync_reg;
  assign stopSeen = sclSync_reg && sclLast_reg && !sdaLast_reg && sdaSync_reg;
  assign byteDone = sclFall && (bitCnt_reg == 4'h8);
  assign wrEn = (state_reg == ST_WDATA) && byteDone;
  assign ptrDec = hwm_decode(ptr_reg);

  // ==========================================================
  // Serial slave sequencer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      txShift_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      isRead_reg <= 1'b0;
      sdaOe <= 1'b0;
    end else if (stopSeen) begin
      state_reg <= ST_IDLE;
      sdaOe <= 1'b0;
    end else if (startSeen) begin
      state_reg <= ST_ADDR;
      bitCnt_reg <= 4'h0;
      sdaOe <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (sclRise) begin
            shift_reg <= {shift_reg[6:0], sdaSync_reg};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (byteDone) begin
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                isRead_reg <= shift_reg[0];
                sdaOe <= 1'b1;
                state_reg <= ST_ADDR_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else if (state_reg == ST_PTR) begin
              if (hwm_decode(shift_reg).valid) begin
                sdaOe <= 1'b1;
                state_reg <= ST_PTR_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else begin
              sdaOe <= 1'b1;
              state_reg <= ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            bitCnt_reg <= 4'h0;
            if (isRead_reg) begin
              txShift_reg <= readByte_reg;
              sdaOe <= !readByte_reg[7];
              state_reg <= ST_RDATA;
            end else begin
              sdaOe <= 1'b0;
              state_reg <= ST_PTR;
            end
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          if (sclFall) begin
            bitCnt_reg <= 4'h0;
            sdaOe <= 1'b0;
            state_reg <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (sclRise) begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (byteDone) begin
            sdaOe <= 1'b0;
            state_reg <= ST_RACK;
          end else if (sclFall) begin
            txShift_reg <= {txShift_reg[6:0], 1'b0};
            sdaOe <= !txShift_reg[6];
          end
        end
        ST_RACK: begin
          if (sclRise) begin
            state_reg <= sdaSync_reg ? ST_IDLE : ST_RLOAD;
          end
        end
        ST_RLOAD: begin
          if (sclFall) begin
            bitCnt_reg <= 4'h0;
            txShift_reg <= readByte_reg;
            sdaOe <= !readByte_reg[7];
            state_reg <= ST_RDATA;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Register pointer, kept between transactions
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_reg <= 8'h00;
    end else if ((state_reg == ST_PTR) && byteDone && hwm_decode(shift_reg).valid) begin
      ptr_reg <= shift_reg;
    end
  end

  // ==========================================================
  // Writable registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        tachCfg[i] <= hwm_pkg::RST_TACH_SETUP;
      end
      control_reg <= hwm_pkg::RST_MONITOR_CONTROL;
      trigger_reg <= hwm_pkg::RST_SINGLE_PASS_TRIGGER;
    end else if (wrEn) begin
      if (ptr_reg == hwm_pkg::OFF_FAN1_TACH_SETUP) begin
        tachCfg[0] <= shift_reg;
      end else if (ptr_reg == hwm_pkg::OFF_FAN2_TACH_SETUP) begin
        tachCfg[1] <= shift_reg;
      end else if (ptr_reg == hwm_pkg::OFF_FAN3_TACH_SETUP) begin
        tachCfg[2] <= shift_reg;
      end else if (ptr_reg == hwm_pkg::OFF_FAN4_TACH_SETUP) begin
        tachCfg[3] <= shift_reg;
      end else if (ptr_reg == hwm_pkg::OFF_MONITOR_CONTROL) begin
        control_reg <= shift_reg & (8'h01 << hwm_pkg::RUN_BIT_POS);
      end else if (ptr_reg == hwm_pkg::OFF_SINGLE_PASS_TRIGGER) begin
        trigger_reg <= shift_reg;
      end
    end
  end

  assign runEnable = control_reg[hwm_pkg::RUN_BIT_POS];

  // ==========================================================
  // Single measurement pass
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      passStart <= 1'b0;
      oneShotActive_reg <= 1'b0;
    end else begin
      passStart <= wrEn && (ptr_reg == hwm_pkg::OFF_SINGLE_PASS_TRIGGER);
      if (wrEn && (ptr_reg == hwm_pkg::OFF_SINGLE_PASS_TRIGGER)) begin
        oneShotActive_reg <= 1'b1;
      end else if (passDone) begin
        oneShotActive_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Result store and readback
  assign storeEn = resultValid && (runEnable || oneShotActive_reg);
  assign storeWord = resultWord;

  hwm_result_mem u_result_mem (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .wrEn(storeEn),
    .wrWord(storeWord),
    .rdChan(ptrDec.chan),
    .rdData(memData)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      readByte_reg <= 8'h00;
    end else if (ptrDec.isResult && (ptrDec.chan >= hwm_pkg::CH_FAN1)) begin
      readByte_reg <= ptrDec.high ? memData[15:8] : memData[7:0];
    end else if (ptrDec.isResult && ptrDec.high) begin
      readByte_reg <= memData[9:2];
    end else if (ptrDec.isResult) begin
      readByte_reg <= {memData[1:0], 6'h00};
    end else if (ptr_reg == hwm_pkg::OFF_FAN1_TACH_SETUP) begin
      readByte_reg <= tachCfg[0];
    end else if (ptr_reg == hwm_pkg::OFF_FAN2_TACH_SETUP) begin
      readByte_reg <= tachCfg[1];
    end else if (ptr_reg == hwm_pkg::OFF_FAN3_TACH_SETUP) begin
      readByte_reg <= tachCfg[2];
    end else if (ptr_reg == hwm_pkg::OFF_FAN4_TACH_SETUP) begin
      readByte_reg <= tachCfg[3];
    end else if (ptr_reg == hwm_pkg::OFF_MONITOR_CONTROL) begin
      readByte_reg <= control_reg;
    end else if (ptr_reg == hwm_pkg::OFF_SINGLE_PASS_TRIGGER) begin
      readByte_reg <= trigger_reg;
    end else begin
      readByte_reg <= 8'h00;
    end
  end

  // Open-drain pin only ever pulls low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  a_low_byte_pos: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ptrDec.isResult && !ptrDec.high && ptrDec.chan < hwm_pkg::CH_FAN1)
    |=> (readByte_reg[7:6] == $past(memData[1:0])) && (readByte_reg[5:0] == 6'h00))
    else $error("Low result byte misplaced");

  a_high_byte_pos: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ptrDec.isResult && ptrDec.high && ptrDec.chan < hwm_pkg::CH_FAN1)
    |=> readByte_reg == $past(memData[9:2]))
    else $error("High result byte misplaced");

  a_fan_count_split: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ptrDec.isResult && ptrDec.chan >= hwm_pkg::CH_FAN1)
    |=> readByte_reg == ($past(ptrDec.high) ? $past(memData[15:8]) : $past(memData[7:0])))
    else $error("Fan count byte wrong");

  a_tach_setup_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wrEn && ptr_reg == hwm_pkg::OFF_FAN2_TACH_SETUP)
    |=> ##1 (readByte_reg == $past(shift_reg, 2)) || (ptr_reg != hwm_pkg::OFF_FAN2_TACH_SETUP))
    else $error("Tach setup readback wrong");

  a_run_bit_ctrl: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wrEn && ptr_reg == hwm_pkg::OFF_MONITOR_CONTROL)
    |=> runEnable == $past(shift_reg[hwm_pkg::RUN_BIT_POS]))
    else $error("Run bit not taken");

  a_trigger_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wrEn && ptr_reg == hwm_pkg::OFF_SINGLE_PASS_TRIGGER)
    |=> ##1 readByte_reg == $past(shift_reg, 2))
    else $error("Trigger readback wrong");

  a_pass_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wrEn && ptr_reg == hwm_pkg::OFF_SINGLE_PASS_TRIGGER)
    |=> passStart && oneShotActive_reg ##1 !passStart)
    else $error("Single pass not requested");

  a_pointer_load: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_reg != ST_PTR) |=> $stable(ptr_reg))
    else $error("Pointer changed outside pointer byte");

endmodule : hwm_monitor_regs

// ==== core/hwm_pkg.sv ====
// Purpose: Shared offsets, reset values, fields and types of the monitor register bank
// Assumes: Byte-wide registers reached through a pointer over the two-wire serial port
// Notes: Result channel numbers index the result store
package hwm_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_FAN1_TACH_SETUP = 8'h04;
  localparam logic [7:0] OFF_FAN2_TACH_SETUP = 8'h05;
  localparam logic [7:0] OFF_FAN3_TACH_SETUP = 8'h06;
  localparam logic [7:0] OFF_FAN4_TACH_SETUP = 8'h07;
  localparam logic [7:0] OFF_CORE_SUPPLY_LOW_BITS = 8'h08;
  localparam logic [7:0] OFF_MONITOR_CONTROL = 8'h09;
  localparam logic [7:0] OFF_ZONE3_TEMP_LOW_BITS = 8'h0E;
  localparam logic [7:0] OFF_SINGLE_PASS_TRIGGER = 8'h0F;
  localparam logic [7:0] OFF_ZONE1_TEMP_LOW_BITS = 8'h10;
  localparam logic [7:0] OFF_RAIL_3V3_LOW_BITS = 8'h11;
  localparam logic [7:0] OFF_RAIL_5V_LOW_BITS = 8'h12;
  localparam logic [7:0] OFF_RAIL_2V5_LOW_BITS = 8'h13;
  localparam logic [7:0] OFF_RAIL_12V_LOW_BITS = 8'h14;
  localparam logic [7:0] OFF_ZONE2_TEMP_LOW_BITS = 8'h15;
  localparam logic [7:0] OFF_RAIL_2V5_HIGH_BITS = 8'h20;
  localparam logic [7:0] OFF_CORE_SUPPLY_HIGH_BITS = 8'h21;
  localparam logic [7:0] OFF_RAIL_3V3_HIGH_BITS = 8'h22;
  localparam logic [7:0] OFF_RAIL_5V_HIGH_BITS = 8'h23;
  localparam logic [7:0] OFF_RAIL_12V_HIGH_BITS = 8'h24;
  localparam logic [7:0] OFF_ZONE1_TEMP_HIGH_BITS = 8'h25;
  localparam logic [7:0] OFF_ZONE2_TEMP_HIGH_BITS = 8'h26;
  localparam logic [7:0] OFF_ZONE3_TEMP_HIGH_BITS = 8'h27;
  localparam logic [7:0] OFF_FAN1_COUNT_LOW = 8'h28;
  localparam logic [7:0] OFF_FAN1_COUNT_HIGH = 8'h29;
  localparam logic [7:0] OFF_FAN2_COUNT_LOW = 8'h2A;
  localparam logic [7:0] OFF_FAN2_COUNT_HIGH = 8'h2B;

  // ==========================================================
  // Reset values and fields
  localparam logic [7:0] RST_TACH_SETUP = 8'h36;
  localparam logic [7:0] RST_MONITOR_CONTROL = 8'h00;
  localparam logic [7:0] RST_SINGLE_PASS_TRIGGER = 8'h00;
  localparam logic [15:0] RST_RESULT = 16'h0000;
  localparam int RUN_BIT_POS = 6;
  localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2E;

  // ==========================================================
  // Result channels
  localparam int NUM_CHANNELS = 10;
  localparam logic [3:0] CH_CORE = 4'h0;
  localparam logic [3:0] CH_2V5 = 4'h1;
  localparam logic [3:0] CH_3V3 = 4'h2;
  localparam logic [3:0] CH_5V = 4'h3;
  localparam logic [3:0] CH_12V = 4'h4;
  localparam logic [3:0] CH_ZONE1 = 4'h5;
  localparam logic [3:0] CH_ZONE2 = 4'h6;
  localparam logic [3:0] CH_ZONE3 = 4'h7;
  localparam logic [3:0] CH_FAN1 = 4'h8;
  localparam logic [3:0] CH_FAN2 = 4'h9;

  typedef struct packed {
    logic [3:0] chan;
    logic [15:0] data;
  } hwm_result_t;

  typedef struct packed {
    logic [1:0] threeWire;
    logic [1:0] blankSel;
    logic [1:0] dwellSel;
    logic [1:0] windowSel;
  } hwm_tach_cfg_t;

  typedef struct packed {
    logic valid;
    logic isResult;
    logic [3:0] chan;
    logic high;
  } hwm_decode_t;

endpackage : hwm_pkg

// ==== core/hwm_result_mem.sv ====
// Purpose: Store of the latest measurement result per channel
// Assumes: One result word written per cycle, all words cleared by reset
// Notes: Read data come out of a register, one cycle after the address
`timescale 1ns/100ps
module hwm_result_mem (
  input wire logic core_clk, // Core clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic wrEn, // Store the word below
  input wire hwm_pkg::hwm_result_t wrWord, // Channel and value
  input wire logic [3:0] rdChan, // Channel to read
  output logic [15:0] rdData // Registered read data
);

  logic [15:0] store [hwm_pkg::NUM_CHANNELS];

  // ==========================================================
  // Write port
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < hwm_pkg::NUM_CHANNELS; i++) begin
        store[i] <= hwm_pkg::RST_RESULT;
      end
    end else if (wrEn && (wrWord.chan <= hwm_pkg::CH_FAN2)) begin
      store[wrWord.chan] <= wrWord.data;
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData <= hwm_pkg::RST_RESULT;
    end else if (rdChan <= hwm_pkg::CH_FAN2) begin
      rdData <= store[rdChan];
    end else begin
      rdData <= hwm_pkg::RST_RESULT;
    end
  end

endmodule : hwm_result_mem

// ==== tb/hwm_smbus_host.sv ====
// Purpose: Two-wire host controller model for the monitor's serial port
// Assumes: Open-drain data line with pull-up, resolved in the bench
// Notes: Clock phases last 8 core cycles; data moves 4 cycles off clock edges
`timescale 1ns/100ps
module hwm_smbus_host #(
  parameter logic [6:0] DEV_ADDR = hwm_pkg::DEFAULT_DEV_ADDR
) (
  input wire logic core_clk, // Core clock
  input wire logic sdaLine, // Resolved data line level
  output logic sclOut, // Serial clock drive
  output logic sdaRel // Data release, 0 pulls low
);
  initial begin
    sclOut = 1'b1;
    sdaRel = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic put_bit(input logic b);
    sdaRel <= b;
    tick(4);
    sclOut <= 1'b1;
    tick(8);
    sclOut <= 1'b0;
    tick(4);
  endtask : put_bit
  task automatic get_bit(output logic b);
    sdaRel <= 1'b1;
    tick(4);
    sclOut <= 1'b1;
    tick(4);
    b = sdaLine;
    tick(4);
    sclOut <= 1'b0;
    tick(4);
  endtask : get_bit
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_bit(a);
    ack = !a;
  endtask : put_byte
  task automatic get_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(last);
  endtask : get_byte
  // Current-pointer read of two bytes, host acknowledges the first
  task automatic read_two(input logic [6:0] dev, output logic [7:0] d0,
      output logic [7:0] d1, output logic ok);
    sdaRel <= 1'b0;
    tick(8);
    sclOut <= 1'b0;
    tick(4);
    put_byte({dev, 1'b1}, ok);
    get_byte(1'b0, d0);
    get_byte(1'b1, d1);
    sdaRel <= 1'b0;
    tick(4);
    sclOut <= 1'b1;
    tick(8);
    sdaRel <= 1'b1;
    tick(8);
  endtask : read_two
  // ==========================================================
  // One transaction: optional pointer, write byte, read byte
  task automatic access(input logic [6:0] dev, input logic doPtr, input logic [7:0] ptr,
      input logic doWr, input logic [7:0] wd, input logic doRd,
      output logic [7:0] rd, output logic ok);
    logic a;
    ok = 1'b1;
    rd = 8'h00;
    sdaRel <= 1'b0;
    tick(8);
    sclOut <= 1'b0;
    tick(4);
    if (doPtr) begin
      put_byte({dev, 1'b0}, a);
      ok &= a;
      put_byte(ptr, a);
      ok &= a;
      if (doWr) begin
        put_byte(wd, a);
        ok &= a;
      end
      if (doRd) begin
        sdaRel <= 1'b1;
        tick(4);
        sclOut <= 1'b1;
        tick(8);
        sdaRel <= 1'b0;
        tick(8);
        sclOut <= 1'b0;
        tick(4);
      end
    end
    if (doRd) begin
      put_byte({dev, 1'b1}, a);
      ok &= a;
      get_byte(1'b1, rd);
    end
    sdaRel <= 1'b0;
    tick(4);
    sclOut <= 1'b1;
    tick(8);
    sdaRel <= 1'b1;
    tick(8);
  endtask : access
endmodule : hwm_smbus_host

// ==== tb/tb.sv ====
// Purpose: Self-checking bench of the monitor register bank
// Assumes: Host model drives the serial port; bench plays the measuring engine
// Notes: Expected values come from the register layout, not from the design
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb;
  localparam logic [6:0] DEV = hwm_pkg::DEFAULT_DEV_ADDR;
  logic core_clk = 1'b0, sys_rst = 1'b1, sclOut, sdaRel, sdaOut, sdaOe, sdaLine;
  logic resultValid = 1'b0, passDone = 1'b0, runEnable, passStart;
  hwm_pkg::hwm_result_t resultWord = '0;
  hwm_pkg::hwm_tach_cfg_t [3:0] tachCfg;
  int mismatches = 0, checked = 0, passCount = 0;
  logic [7:0] lowOff[10] = '{8'h08, 8'h13, 8'h11, 8'h12, 8'h14, 8'h10, 8'h15, 8'h0E, 8'h28, 8'h2A};
  logic [7:0] highOff[10] = '{8'h21, 8'h20, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29, 8'h2B};
  assign sdaLine = sdaRel & (sdaOe ? sdaOut : 1'b1);
  hwm_monitor_regs #(.DEV_ADDR(DEV)) hwm_monitor_regs_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .sclIn(sclOut), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .resultValid(resultValid), .resultWord(resultWord), .passDone(passDone),
    .runEnable(runEnable), .passStart(passStart), .tachCfg(tachCfg));
  hwm_smbus_host #(.DEV_ADDR(DEV)) hwm_smbus_host_i (.core_clk(core_clk),
    .sdaLine(sdaLine), .sclOut(sclOut), .sdaRel(sdaRel));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (passStart === 1'b1) begin
      passCount++;
    end
  end
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  // ==========================================================
  // Bus and engine helpers
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic ok;
    hwm_smbus_host_i.access(DEV, 1'b1, p, 1'b0, 8'h00, 1'b1, d, ok);
    `CHK("read ack", 1'b1, ok)
  endtask : rd
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic ok;
    logic [7:0] d;
    hwm_smbus_host_i.access(DEV, 1'b1, p, 1'b1, v, 1'b0, d, ok);
    `CHK("write ack", 1'b1, ok)
  endtask : wr
  task automatic expect_reg(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    rd(p, d);
    `CHK($sformatf("register %0h", p), e, d)
  endtask : expect_reg
  task automatic post(input logic [3:0] ch, input logic [15:0] v);
    @(posedge core_clk);
    resultValid <= 1'b1;
    resultWord <= {ch, v};
    @(posedge core_clk);
    resultValid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : post
  // ==========================================================
  // Scenarios
  task automatic test_defaults();
    logic ok;
    logic [7:0] d;
    `CHK("run level", 1'b0, runEnable)
    `CHK("fan4 setup", 8'h36, tachCfg[3])
    for (int p = 0; p < 48; p++) begin
      if ((p >= 4 && p <= 9) || (p >= 14 && p <= 21) || (p >= 32 && p <= 43)) begin
        expect_reg(8'(p), (p < 8) ? 8'h36 : 8'h00);
      end else begin
        hwm_smbus_host_i.access(DEV, 1'b1, 8'(p), 1'b0, 8'h00, 1'b0, d, ok);
        `CHK("bad pointer ack", 1'b0, ok)
      end
    end
    $display("test defaults done");
  endtask : test_defaults
  task automatic test_tach();
    logic [7:0] v[4] = '{8'hC9, 8'h72, 8'h1B, 8'hE4};
    for (int i = 0; i < 4; i++) begin
      wr(8'h04 + 8'(i), v[i]);
      `CHK("three-wire field", v[i][7:6], tachCfg[i].threeWire)
      `CHK("blank field", v[i][5:4], tachCfg[i].blankSel)
      `CHK("dwell field", v[i][3:2], tachCfg[i].dwellSel)
      `CHK("window field", v[i][1:0], tachCfg[i].windowSel)
      expect_reg(8'h04 + 8'(i), v[i]);
    end
    $display("test tach done");
  endtask : test_tach
  task automatic test_results();
    logic [15:0] v;
    wr(8'h09, 8'hFF);
    expect_reg(8'h09, 8'h40);
    `CHK("run level", 1'b1, runEnable)
    for (int c = 0; c < 10; c++) begin
      v = (c < 8) ? 16'(10'h2C9 + 10'(c * 83)) : 16'hA53C + 16'(c);
      post(4'(c), v);
      expect_reg(lowOff[c], (c < 8) ? {v[1:0], 6'h00} : v[7:0]);
      expect_reg(highOff[c], (c < 8) ? v[9:2] : v[15:8]);
    end
    wr(8'h21, 8'hFF);
    expect_reg(8'h21, 8'hB2);
    wr(8'h09, 8'hBF);
    expect_reg(8'h09, 8'h00);
    `CHK("run level", 1'b0, runEnable)
    $display("test results done");
  endtask : test_results
  task automatic test_single_pass();
    int n;
    post(hwm_pkg::CH_ZONE1, 16'h03FF);
    expect_reg(8'h25, 8'h1A);
    n = passCount;
    wr(8'h0F, 8'hA5);
    `CHK("pass starts", n + 1, passCount)
    expect_reg(8'h0F, 8'hA5);
    post(hwm_pkg::CH_ZONE1, 16'h0155);
    expect_reg(8'h25, 8'h55);
    @(posedge core_clk);
    passDone <= 1'b1;
    @(posedge core_clk);
    passDone <= 1'b0;
    post(hwm_pkg::CH_ZONE1, 16'h03FF);
    expect_reg(8'h25, 8'h55);
    $display("test single pass done");
  endtask : test_single_pass
  task automatic test_pointer();
    logic ok;
    logic [7:0] d;
    logic [7:0] d2;
    hwm_smbus_host_i.access(DEV, 1'b1, 8'h29, 1'b0, 8'h00, 1'b0, d, ok);
    `CHK("pointer ack", 1'b1, ok)
    for (int k = 0; k < 2; k++) begin
      hwm_smbus_host_i.access(DEV, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1, d, ok);
      `CHK("current read", 8'hA5, d)
    end
    hwm_smbus_host_i.read_two(DEV, d, d2, ok);
    `CHK("acked read address", 1'b1, ok)
    `CHK("first of two bytes", 8'hA5, d)
    `CHK("repeated byte", 8'hA5, d2)
    `CHK("drive value", 1'b0, sdaOut)
    hwm_smbus_host_i.access(DEV ^ 7'h01, 1'b1, 8'h04, 1'b0, 8'h00, 1'b0, d, ok);
    `CHK("foreign address ack", 1'b0, ok)
    hwm_smbus_host_i.access(DEV, 1'b1, 8'h30, 1'b0, 8'h00, 1'b0, d, ok);
    hwm_smbus_host_i.access(DEV, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1, d, ok);
    `CHK("kept pointer read", 8'hA5, d)
    $display("test pointer done");
  endtask : test_pointer
  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    test_defaults();
    test_tach();
    test_results();
    test_single_pass();
    test_pointer();
    give_verdict();
  end
endmodule : tb
